/* File: design/cpwm_defines.svh */
`ifndef CPWM_DEFINES_SVH
`define CPWM_DEFINES_SVH

// Register byte addresses
`define CPWM_ADDR_MODE 8'h00
`define CPWM_ADDR_CTRL 8'h04
`define CPWM_ADDR_STATUS 8'h08
`define CPWM_ADDR_COUNT 8'h0c
`define CPWM_ADDR_PBUF 8'h10
`define CPWM_ADDR_PDR 8'h14
`define CPWM_ADDR_DEAD 8'h18
`define CPWM_ADDR_PHASE_BASE 8'h20
`define CPWM_PHASE_STRIDE 8'h20

// Slots inside one phase block (word index)
`define CPWM_SLOT_BUF 3'h0
`define CPWM_SLOT_FREE 3'h1
`define CPWM_SLOT_DOWN 3'h2
`define CPWM_SLOT_MID 3'h3
`define CPWM_SLOT_UP 3'h4

// mode_and_level fields
`define CPWM_MODE_XFER_LO 0
`define CPWM_MODE_XFER_HI 1
`define CPWM_MODE_POS_LEVEL 2
`define CPWM_MODE_NEG_LEVEL 3
`define CPWM_MODE_PRE_LO 4
`define CPWM_MODE_PRE_HI 5

// Transfer timing encodings
`define CPWM_XFER_CREST 2'h0
`define CPWM_XFER_TROUGH 2'h1
`define CPWM_XFER_BOTH 2'h2
`define CPWM_XFER_NONE 2'h3

// run_and_irq_control fields
`define CPWM_CTRL_START 0
`define CPWM_CTRL_LOCK 3
`define CPWM_CTRL_IRQ_EN 6

// match_status fields
`define CPWM_STAT_PERIOD 0
`define CPWM_STAT_TWO_DT 1

// Reset values
`define CPWM_RST_MODE 8'h00
`define CPWM_RST_CTRL 8'h00
`define CPWM_RST_WORD 16'h0000

// AXI responses
`define CPWM_RESP_OKAY 2'h0
`define CPWM_RESP_SLVERR 2'h2

`endif

/* File: design/cpwm_pkg.sv */
package cpwm_pkg;

    typedef enum logic {
        CPWM_DIR_UP,
        CPWM_DIR_DOWN
    } cpwm_dir_t;

    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] mode;
        logic [7:0] ctrl;
        logic [1:0] status;
        logic [15:0] count;
        cpwm_dir_t dir;
        logic [15:0] pbuf;
        logic [15:0] pdr;
        logic [15:0] dead;
        logic [5:0] pre;
        logic [2:0][15:0] duty;
        logic [2:0][15:0] cmp_down;
        logic [2:0][15:0] cmp_mid;
        logic [2:0][15:0] cmp_up;
        logic [2:0] pos_on;
        logic [2:0] neg_on;
        logic [2:0] pos_pin;
        logic [2:0] neg_pin;
    } cpwm_state_t;

endpackage

/* File: design/cpwm_top.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "cpwm_defines.svh"

module cpwm_top
    import cpwm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic phase_u_positive_out,
    output logic phase_u_negative_out,
    output logic phase_v_positive_out,
    output logic phase_v_negative_out,
    output logic phase_w_positive_out,
    output logic phase_w_negative_out,
    output logic period_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] ws
    );
        logic [15:0] r;
        r = old;
        if (ws[0])
        begin
            r[7:0] = wd[7:0];
        end
        if (ws[1])
        begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    function automatic logic [15:0] add16(
        input logic [15:0] a,
        input logic [15:0] b
    );
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0];
    endfunction

    function automatic logic [15:0] twice(
        input logic [15:0] a
    );
        return {a[14:0], 1'b0};
    endfunction

    // Phase index from an address inside the phase blocks, 2'h3 when outside
    function automatic logic [1:0] phase_of(
        input logic [7:0] a
    );
        logic [1:0] p;
        p = 2'h3;
        if (a >= `CPWM_ADDR_PHASE_BASE && a < 8'h80)
        begin
            p = a[6:5] - 2'h1;
        end
        return p;
    endfunction

    function automatic logic addr_ok(
        input logic [7:0] a,
        input logic for_write
    );
        logic ok;
        ok = 1'b0;
        case (a)
            `CPWM_ADDR_MODE, `CPWM_ADDR_CTRL, `CPWM_ADDR_STATUS, `CPWM_ADDR_COUNT,
            `CPWM_ADDR_PBUF, `CPWM_ADDR_DEAD: ok = 1'b1;
            `CPWM_ADDR_PDR: ok = !for_write;
            default:
            begin
                if (phase_of(a) != 2'h3 && a[1:0] == 2'h0)
                begin
                    if (a[4:2] == `CPWM_SLOT_BUF || a[4:2] == `CPWM_SLOT_FREE)
                    begin
                        ok = 1'b1;
                    end
                    else if (a[4:2] <= `CPWM_SLOT_UP)
                    begin
                        ok = !for_write;
                    end
                end
            end
        endcase
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    cpwm_state_t st_ff;
    cpwm_state_t nxt_st;

    // Readies drop while frozen so that no request is taken and then lost
    assign s_axi_awready = clk_en && !st_ff.aw_have && !st_ff.bvalid;
    assign s_axi_wready = clk_en && !st_ff.w_have && !st_ff.bvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = clk_en && !st_ff.rvalid;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign phase_u_positive_out = st_ff.pos_pin[0];
    assign phase_u_negative_out = st_ff.neg_pin[0];
    assign phase_v_positive_out = st_ff.pos_pin[1];
    assign phase_v_negative_out = st_ff.neg_pin[1];
    assign phase_w_positive_out = st_ff.pos_pin[2];
    assign phase_w_negative_out = st_ff.neg_pin[2];
    assign period_irq = st_ff.status[`CPWM_STAT_PERIOD] && st_ff.ctrl[`CPWM_CTRL_IRQ_EN];

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic running;
        logic tick;
        logic crest;
        logic trough;
        logic xfer;
        logic do_write;
        logic wr_ok;
        logic [1:0] ph;
        logic [1:0] xsel;
        logic [1:0] events;
        logic [5:0] pre_max;
        running = 1'b0;
        tick = 1'b0;
        crest = 1'b0;
        trough = 1'b0;
        xfer = 1'b0;
        do_write = 1'b0;
        wr_ok = 1'b0;
        ph = 2'h3;
        xsel = 2'h0;
        events = 2'h0;
        pre_max = 6'h00;
        nxt_st = st_ff;

        // Bus handshakes
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_st.w_have = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.rvalid && s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
        end

        // Prescaler: divide by 1, 4, 16 or 64
        case (st_ff.mode[`CPWM_MODE_PRE_HI:`CPWM_MODE_PRE_LO])
            2'h0: pre_max = 6'h00;
            2'h1: pre_max = 6'h03;
            2'h2: pre_max = 6'h0f;
            default: pre_max = 6'h3f;
        endcase
        running = st_ff.ctrl[`CPWM_CTRL_START];
        if (running)
        begin
            if (st_ff.pre >= pre_max)
            begin
                nxt_st.pre = 6'h00;
                tick = 1'b1;
            end
            else
            begin
                nxt_st.pre = st_ff.pre + 6'h01;
            end
        end
        else
        begin
            nxt_st.pre = 6'h00;
        end

        // Counter, matches and pins move on the counting edge; a halt turns the pins inactive without one
        if (tick)
        begin
            if (st_ff.dir == CPWM_DIR_UP)
            begin
                if (st_ff.count == st_ff.pdr)
                begin
                    crest = 1'b1;
                    nxt_st.dir = CPWM_DIR_DOWN;
                    nxt_st.count = st_ff.count - 16'h0001;
                end
                else
                begin
                    nxt_st.count = st_ff.count + 16'h0001;
                end
            end
            else
            begin
                if (st_ff.count == 16'h0000)
                begin
                    trough = 1'b1;
                    nxt_st.dir = CPWM_DIR_UP;
                    nxt_st.count = 16'h0001;
                end
                else
                begin
                    nxt_st.count = st_ff.count - 16'h0001;
                end
            end
            events[`CPWM_STAT_PERIOD] = crest;
            events[`CPWM_STAT_TWO_DT] = (st_ff.count == twice(st_ff.dead));
            for (int i = 0; i < 3; i++)
            begin
                if (st_ff.dir == CPWM_DIR_UP)
                begin
                    if (st_ff.count == st_ff.cmp_up[i])
                    begin
                        nxt_st.pos_on[i] = 1'b1;
                    end
                    if (st_ff.count == st_ff.cmp_mid[i])
                    begin
                        nxt_st.neg_on[i] = 1'b0;
                    end
                end
                else
                begin
                    if (st_ff.count == st_ff.cmp_mid[i])
                    begin
                        nxt_st.pos_on[i] = 1'b0;
                    end
                    if (st_ff.count == st_ff.cmp_down[i])
                    begin
                        nxt_st.neg_on[i] = 1'b1;
                    end
                end
            end
        end
        if (!running)
        begin
            nxt_st.pos_on = 3'h0;
            nxt_st.neg_on = 3'h0;
        end

        // Period data follows its buffer at the trough or while halted
        if (trough || !running)
        begin
            nxt_st.pdr = add16(st_ff.pbuf, twice(st_ff.dead));
        end

        // Buffered duty transfer at the selected moment
        xsel = st_ff.mode[`CPWM_MODE_XFER_HI:`CPWM_MODE_XFER_LO];
        case (xsel)
            `CPWM_XFER_CREST: xfer = crest;
            `CPWM_XFER_TROUGH: xfer = trough;
            `CPWM_XFER_BOTH: xfer = crest || trough;
            default: xfer = 1'b0;
        endcase
        if (xfer)
        begin
            for (int i = 0; i < 3; i++)
            begin
                nxt_st.cmp_down[i] = st_ff.duty[i];
                nxt_st.cmp_mid[i] = add16(st_ff.duty[i], st_ff.dead);
                nxt_st.cmp_up[i] = add16(st_ff.duty[i], twice(st_ff.dead));
            end
        end

        // Register write, once address and data are both held
        do_write = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
        if (do_write)
        begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have = 1'b0;
            nxt_st.bvalid = 1'b1;
            wr_ok = addr_ok(st_ff.aw_addr, 1'b1);
            if (st_ff.ctrl[`CPWM_CTRL_LOCK] && st_ff.aw_addr != `CPWM_ADDR_CTRL)
            begin
                wr_ok = 1'b0;
            end
            nxt_st.bresp = wr_ok ? `CPWM_RESP_OKAY : `CPWM_RESP_SLVERR;
            if (wr_ok)
            begin
                ph = phase_of(st_ff.aw_addr);
                case (st_ff.aw_addr)
                    `CPWM_ADDR_MODE:
                    begin
                        if (st_ff.w_strb[0])
                        begin
                            nxt_st.mode = st_ff.w_data[7:0];
                        end
                    end
                    `CPWM_ADDR_CTRL:
                    begin
                        if (st_ff.w_strb[0])
                        begin
                            nxt_st.ctrl = st_ff.w_data[7:0];
                        end
                    end
                    `CPWM_ADDR_STATUS:
                    begin
                        if (st_ff.w_strb[0])
                        begin
                            nxt_st.status = st_ff.status & st_ff.w_data[1:0];
                        end
                    end
                    `CPWM_ADDR_COUNT: nxt_st.count = merge16(st_ff.count, st_ff.w_data,
                        st_ff.w_strb);
                    `CPWM_ADDR_PBUF: nxt_st.pbuf = merge16(st_ff.pbuf, st_ff.w_data,
                        st_ff.w_strb);
                    `CPWM_ADDR_DEAD: nxt_st.dead = merge16(st_ff.dead, st_ff.w_data,
                        st_ff.w_strb);
                    default:
                    begin
                        nxt_st.duty[ph] = merge16(st_ff.duty[ph], st_ff.w_data, st_ff.w_strb);
                        if (st_ff.aw_addr[4:2] == `CPWM_SLOT_FREE)
                        begin
                            nxt_st.cmp_down[ph] = nxt_st.duty[ph];
                            nxt_st.cmp_mid[ph] = add16(nxt_st.duty[ph], st_ff.dead);
                            nxt_st.cmp_up[ph] = add16(nxt_st.duty[ph], twice(st_ff.dead));
                        end
                    end
                endcase
            end
        end

        // Events win over a clear in the same cycle
        nxt_st.status = nxt_st.status | events;

        // Register read
        if (s_axi_arvalid && s_axi_arready)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = 32'h0000_0000;
            nxt_st.rresp = addr_ok(s_axi_araddr, 1'b0) ? `CPWM_RESP_OKAY : `CPWM_RESP_SLVERR;
            ph = phase_of(s_axi_araddr);
            case (s_axi_araddr)
                `CPWM_ADDR_MODE: nxt_st.rdata[7:0] = st_ff.mode;
                `CPWM_ADDR_CTRL: nxt_st.rdata[7:0] = st_ff.ctrl;
                `CPWM_ADDR_STATUS: nxt_st.rdata[1:0] = st_ff.status;
                `CPWM_ADDR_COUNT: nxt_st.rdata[15:0] = st_ff.count;
                `CPWM_ADDR_PBUF: nxt_st.rdata[15:0] = st_ff.pbuf;
                `CPWM_ADDR_PDR: nxt_st.rdata[15:0] = st_ff.pdr;
                `CPWM_ADDR_DEAD: nxt_st.rdata[15:0] = st_ff.dead;
                default:
                begin
                    if (ph != 2'h3 && s_axi_araddr[1:0] == 2'h0)
                    begin
                        case (s_axi_araddr[4:2])
                            `CPWM_SLOT_BUF, `CPWM_SLOT_FREE: nxt_st.rdata[15:0] = st_ff.duty[ph];
                            `CPWM_SLOT_DOWN: nxt_st.rdata[15:0] = st_ff.cmp_down[ph];
                            `CPWM_SLOT_MID: nxt_st.rdata[15:0] = st_ff.cmp_mid[ph];
                            `CPWM_SLOT_UP: nxt_st.rdata[15:0] = st_ff.cmp_up[ph];
                            default: nxt_st.rdata = 32'h0000_0000;
                        endcase
                    end
                end
            endcase
        end

        // Pin levels with selectable active level; halted pins sit inactive
        for (int i = 0; i < 3; i++)
        begin
            nxt_st.pos_pin[i] = nxt_st.pos_on[i] ~^ nxt_st.mode[`CPWM_MODE_POS_LEVEL];
            nxt_st.neg_pin[i] = nxt_st.neg_on[i] ~^ nxt_st.mode[`CPWM_MODE_NEG_LEVEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            st_ff <= '0;
            st_ff.mode <= `CPWM_RST_MODE;
            st_ff.ctrl <= `CPWM_RST_CTRL;
            st_ff.pos_pin <= 3'h7;
            st_ff.neg_pin <= 3'h7;
        end
        else if (clk_en)
        begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire

/* File: verification/cpwm_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module cpwm_top_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic phase_u_positive_out,
    input wire logic phase_u_negative_out,
    input wire logic period_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && clk_en |-> ##[1:2] s_axi_bvalid) else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en
        |=> s_axi_rvalid) else $error("no read response");
    a_freeze_pins: assert property (!clk_en |=>
        $stable({phase_u_positive_out, phase_u_negative_out, s_axi_bvalid, s_axi_rvalid}))
        else $error("state moved while frozen");
    a_irq_stays: assert property (period_irq && !s_axi_awvalid &&
        !$past(s_axi_awvalid) |=> period_irq) else $error("interrupt lost without write");
endmodule

bind cpwm_top cpwm_top_chk u_chk (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .phase_u_positive_out(phase_u_positive_out),
    .phase_u_negative_out(phase_u_negative_out), .period_irq(period_irq));
`default_nettype wire

/* File: verification/cpwm_switch_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cpwm_switch_model #(
    parameter bit ACT = 1'b1
) (
    input wire logic clk,
    input wire logic watch,
    input wire logic [2:0] pos,
    input wire logic [2:0] neg,
    output var int shoot,
    output var int min_gap
);
    int gap;
    initial
    begin
        shoot = 0;
        min_gap = 9999;
        gap = 0;
    end
    // Both switches of a leg on at once would short the supply
    always @(posedge clk)
    begin
        if (watch)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (pos[i] == ACT && neg[i] == ACT)
                    shoot = shoot + 1;
            end
            if (pos[0] != ACT && neg[0] != ACT)
                gap = gap + 1;
            else
            begin
                if (gap > 0 && gap < min_gap)
                    min_gap = gap;
                gap = 0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpwm_defines.svh"
module tb_top;
    import cpwm_pkg::*;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, irq, watch = 1'b0;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] pos, neg;
    int n_tests = 0, n_fail = 0, shoot, min_gap;
    cpwm_top DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .phase_u_positive_out(pos[0]), .phase_u_negative_out(neg[0]),
        .phase_v_positive_out(pos[1]), .phase_v_negative_out(neg[1]),
        .phase_w_positive_out(pos[2]), .phase_w_negative_out(neg[2]), .period_irq(irq));
    cpwm_switch_model #(.ACT(1'b1)) u_sw (.clk(sys_clk), .watch(watch), .pos(pos),
        .neg(neg), .shoot(shoot), .min_gap(min_gap));
    always #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aon, won, aok, wok;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aon = 1'b1;
        won = 1'b1;
        while (aon || won)
        begin
            @(negedge sys_clk);
            aok = aon && awready;
            wok = won && wready;
            @(posedge sys_clk);
            if (aok) awvalid <= 1'b0;
            if (aok) aon = 1'b0;
            if (wok) wvalid <= 1'b0;
            if (wok) won = 1'b0;
        end
        aok = 1'b0;
        while (!aok)
        begin
            @(negedge sys_clk);
            aok = bvalid;
            wok = (bresp === er);
            @(posedge sys_clk);
        end
        bready <= 1'b0;
        `CHK("write response", 1'b1, wok)
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ok;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ok = 1'b0;
        while (!ok)
        begin
            @(negedge sys_clk);
            ok = arready;
            @(posedge sys_clk);
        end
        arvalid <= 1'b0;
        ok = 1'b0;
        while (!ok)
        begin
            @(negedge sys_clk);
            ok = rvalid;
            d = rdata;
            r = rresp;
            @(posedge sys_clk);
        end
        rready <= 1'b0;
        `CHK("read data", e, d)
        `CHK("read response", er, r)
        @(posedge sys_clk);
    endtask
    function automatic logic [7:0] pa(input int p, input logic [2:0] s);
        return `CPWM_ADDR_PHASE_BASE + 8'(p) * `CPWM_PHASE_STRIDE + {3'h0, s, 2'h0};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        rd(`CPWM_ADDR_MODE, 32'h0, `CPWM_RESP_OKAY);
        rd(`CPWM_ADDR_CTRL, 32'h0, `CPWM_RESP_OKAY);
        rd(`CPWM_ADDR_DEAD, 32'h0, `CPWM_RESP_OKAY);
    endtask
    task automatic t_period();
        wr(`CPWM_ADDR_DEAD, 32'h4, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_PBUF, 32'h28, `CPWM_RESP_OKAY);
        rd(`CPWM_ADDR_PDR, 32'h30, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_PDR, 32'h7, `CPWM_RESP_SLVERR);
        rd(`CPWM_ADDR_PDR, 32'h30, `CPWM_RESP_OKAY);
        rd(8'h1c, 32'h0, `CPWM_RESP_SLVERR);
    endtask
    task automatic t_duty();
        wr(`CPWM_ADDR_MODE, 32'h0c, `CPWM_RESP_OKAY);
        wr(pa(1, `CPWM_SLOT_FREE), 32'ha, `CPWM_RESP_OKAY);
        rd(pa(1, `CPWM_SLOT_DOWN), 32'ha, `CPWM_RESP_OKAY);
        rd(pa(1, `CPWM_SLOT_MID), 32'he, `CPWM_RESP_OKAY);
        rd(pa(1, `CPWM_SLOT_UP), 32'h12, `CPWM_RESP_OKAY);
        wr(pa(2, `CPWM_SLOT_FREE), 32'h14, `CPWM_RESP_OKAY);
        wr(pa(0, `CPWM_SLOT_BUF), 32'ha, `CPWM_RESP_OKAY);
        rd(pa(0, `CPWM_SLOT_DOWN), 32'h0, `CPWM_RESP_OKAY);
    endtask
    task automatic t_run();
        wr(`CPWM_ADDR_CTRL, 32'h41, `CPWM_RESP_OKAY);
        while (irq !== 1'b1) @(posedge sys_clk);
        rd(`CPWM_ADDR_STATUS, 32'h3, `CPWM_RESP_OKAY);
        rd(pa(0, `CPWM_SLOT_UP), 32'h12, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_STATUS, 32'h0, `CPWM_RESP_OKAY);
        `CHK("interrupt after clear", 1'b0, irq)
        watch <= 1'b1;
        repeat (300) @(posedge sys_clk);
        watch <= 1'b0;
        @(posedge sys_clk);
        `CHK("overlap count", 0, shoot)
        `CHK("dead gap", 4, min_gap)
    endtask
    task automatic t_lock_halt();
        wr(`CPWM_ADDR_CTRL, 32'h49, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_DEAD, 32'h5, `CPWM_RESP_SLVERR);
        rd(`CPWM_ADDR_DEAD, 32'h4, `CPWM_RESP_OKAY);
        clk_en <= 1'b0;
        repeat (3) @(posedge sys_clk);
        clk_en <= 1'b1;
        wr(`CPWM_ADDR_CTRL, 32'h0, `CPWM_RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        `CHK("halted pins", 6'h00, {pos, neg})
    endtask
    task automatic t_modes();
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        `CHK("reset pins", 6'h3f, {pos, neg})
        wr(`CPWM_ADDR_COUNT, 32'h1234, `CPWM_RESP_OKAY);
        rd(`CPWM_ADDR_COUNT, 32'h1234, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_COUNT, 32'h0, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_DEAD, 32'h4, `CPWM_RESP_OKAY);
        wstrb <= 4'h2;
        wr(`CPWM_ADDR_DEAD, 32'h0305, `CPWM_RESP_OKAY);
        wstrb <= 4'hf;
        rd(`CPWM_ADDR_DEAD, 32'h0304, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_DEAD, 32'h4, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_PBUF, 32'h28, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_MODE, 32'h1d, `CPWM_RESP_OKAY);
        wr(pa(0, `CPWM_SLOT_BUF), 32'h6, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_CTRL, 32'h1, `CPWM_RESP_OKAY);
        // Divide by four: only the twice-dead-time match so far
        repeat (100) @(posedge sys_clk);
        rd(`CPWM_ADDR_STATUS, 32'h2, `CPWM_RESP_OKAY);
        // Past the crest, before the trough: no transfer yet
        repeat (150) @(posedge sys_clk);
        rd(`CPWM_ADDR_STATUS, 32'h3, `CPWM_RESP_OKAY);
        rd(pa(0, `CPWM_SLOT_DOWN), 32'h0, `CPWM_RESP_OKAY);
        // Past the trough: buffer has reached the compares
        repeat (200) @(posedge sys_clk);
        rd(pa(0, `CPWM_SLOT_DOWN), 32'h6, `CPWM_RESP_OKAY);
        rd(pa(0, `CPWM_SLOT_UP), 32'he, `CPWM_RESP_OKAY);
        wr(`CPWM_ADDR_CTRL, 32'h0, `CPWM_RESP_OKAY);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_reset_vals();
        t_period();
        t_duty();
        t_run();
        t_lock_halt();
        t_modes();
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        report_and_stop();
    end
endmodule
`default_nettype wire
